// file: bench/spbcr_host_model.sv
// APB host model issuing configuration accesses
module spbcr_host_model (
  // Clock
  input  wire logic        pclk,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  // Answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
  end

  // ********************************************************************
  // One transfer, held until pready is seen high or 64 cycles have passed
  // ********************************************************************
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic late);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd   = prdata;
    err  = pslverr;
    late = (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines show the inverse, never a stale value; pwrite keeps its value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer

endmodule : spbcr_host_model

// file: bench/tb_top.sv
// Register bank testbench: APB accesses, events and I/O routing queries
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [11:0] PIN_A  = {spbcr_pkg::PIN_IDX, 2'b00};
  localparam logic [11:0] BRCTL_A = {spbcr_pkg::BRCTL_IDX, 2'b00};
  localparam logic [11:0] LOCK_A = {spbcr_pkg::LOCK_IDX, 2'b00};
  localparam logic [11:0] CAP_A  = {spbcr_pkg::CAP_IDX, 2'b00};
  localparam logic [31:0] CAP_DN = {1'b0, spbcr_pkg::TCR_RST, 5'h00, spbcr_pkg::SLOT_RST,
    spbcr_pkg::TYPE_DOWN, spbcr_pkg::VSN_RST, spbcr_pkg::NEXT_RST, spbcr_pkg::CAP_ID};

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [3:0] pstrb;
  logic upstream = 1'b0;
  logic [2:0] ev = 3'b000;
  logic cmd_en = 1'b0;
  logic dev_en = 1'b0;
  logic io_req = 1'b0;
  logic [31:0] io_addr = 32'h0000_0000;
  logic poison_report, err_forward, io_fwd_down, io_fwd_up;
  logic sec_reset_up, sec_reset_down, err_v, late_v;
  logic [7:0] legacy_int_pin;
  int fails = 0;
  int check_count = 0;
  // control[7:0], addr[15:0], down, up
  logic [25:0] tab [0:9] = '{{8'h00, 16'h2300, 2'b10}, {8'h04, 16'h2300, 2'b01},
    {8'h04, 16'h2000, 2'b10}, {8'h00, 16'h3300, 2'b00}, {8'h00, 16'h03C0, 2'b00},
    {8'h08, 16'h03C0, 2'b10}, {8'h08, 16'h13C0, 2'b10}, {8'h18, 16'h13C0, 2'b00},
    {8'h18, 16'h03C0, 2'b10}, {8'h10, 16'h03C0, 2'b00}};

  always #2.5 pclk = ~pclk;

  spbcr_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_is_upstream(upstream),
    .sec_poison_seen(ev[0]), .sec_err_nonfatal(ev[1]), .sec_err_fatal(ev[2]),
    .cmd_serr_enable(cmd_en), .dev_ctl_report_enable(dev_en), .io_req(io_req),
    .io_addr(io_addr), .io_base(32'h0000_2000), .io_limit(32'h0000_2FFF),
    .poison_report(poison_report), .err_forward(err_forward), .io_fwd_down(io_fwd_down),
    .io_fwd_up(io_fwd_up), .sec_reset_up(sec_reset_up), .sec_reset_down(sec_reset_down),
    .legacy_int_pin(legacy_int_pin));

  spbcr_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    host.xfer(1'b1, a, d, rd_v, err_v, late_v);
    check(late_v, 1'b0);
    check(err_v, e);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
    host.xfer(1'b0, a, 32'h0000_0000, rd_v, err_v, late_v);
    check(late_v, 1'b0);
    check(err_v, e);
    check(rd_v, exp);
  endtask : rdc

  task automatic pulse(input logic [2:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 3'b000;
    #1;
  endtask : pulse

  task automatic io(input logic [31:0] a);
    @(posedge pclk);
    io_req  <= 1'b1;
    io_addr <= a;
    @(posedge pclk);
    io_req  <= 1'b0;
    #1;
  endtask : io

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(PIN_A, 32'h0000_0000, 1'b0);
    rdc(BRCTL_A, 32'h0000_0000, 1'b0);
    rdc(CAP_A, CAP_DN, 1'b0);
    $display("Test reset values done");
    // Codes kept within zero to four
    for (int i = 0; i < 5; i++) begin
      wr(PIN_A, 32'(i), 1'b0);
      rdc(PIN_A, 32'(i), 1'b0);
      check(legacy_int_pin, 32'(i));
    end
    $display("Test interrupt pin done");
    wr(BRCTL_A, 32'h0000_FFFF, 1'b0);
    rdc(BRCTL_A, {16'h0000, spbcr_pkg::BRCTL_WMASK}, 1'b0);
    check(sec_reset_down, 1'b1);
    check(sec_reset_up, 1'b0);
    wr(BRCTL_A, 32'h0000_0000, 1'b0);
    pulse(3'b001);
    check(poison_report, 1'b0);
    wr(BRCTL_A, 32'h0000_0001, 1'b0);
    pulse(3'b001);
    check(poison_report, 1'b1);
    wr(BRCTL_A, 32'h0000_0002, 1'b0);
    pulse(3'b010);
    check(err_forward, 1'b0);
    @(posedge pclk);
    cmd_en <= 1'b1;
    pulse(3'b100);
    check(err_forward, 1'b1);
    @(posedge pclk);
    cmd_en <= 1'b0;
    dev_en <= 1'b1;
    pulse(3'b010);
    check(err_forward, 1'b1);
    wr(BRCTL_A, 32'h0000_0000, 1'b0);
    pulse(3'b010);
    check(err_forward, 1'b0);
    $display("Test bridge control events done");
    for (int i = 0; i < 10; i++) begin
      wr(BRCTL_A, {24'h000000, tab[i][25:18]}, 1'b0);
      io({16'h0000, tab[i][17:2]});
      check(io_fwd_down, tab[i][1]);
      check(io_fwd_up, tab[i][0]);
    end
    $display("Test I/O routing done");
    wr(LOCK_A, 32'h0000_0001, 1'b0);
    wr(CAP_A, 32'hFFFF_FFFF, 1'b0);
    rdc(CAP_A, CAP_DN, 1'b0);
    wr(LOCK_A, 32'h0000_0000, 1'b0);
    wr(CAP_A, 32'hFFFF_FFFF, 1'b0);
    rdc(CAP_A, 32'h416F_FF10, 1'b0);
    wr(CAP_A, 32'h0000_0000, 1'b0);
    rdc(CAP_A, 32'h0060_0010, 1'b0);
    wr(12'h200, 32'hFFFF_FFFF, 1'b1);
    rdc(12'h200, 32'h0000_0000, 1'b1);
    $display("Test capability and lock done");
    // Upstream port: slot bit is left at zero from here on
    @(posedge pclk);
    presetn  <= 1'b0;
    upstream <= 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CAP_A, {CAP_DN[31:24], spbcr_pkg::TYPE_UP, CAP_DN[19:0]}, 1'b0);
    rdc(PIN_A, 32'h0000_0000, 1'b0);
    wr(BRCTL_A, 32'h0000_0040, 1'b0);
    rdc(BRCTL_A, 32'h0000_0040, 1'b0);
    check(sec_reset_up, 1'b1);
    check(sec_reset_down, 1'b0);
    $display("Test upstream port done");
    complete_run();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    complete_run();
  end

endmodule : tb_top

// file: hw/spbcr_io_decode.sv
// I/O address routing decode for the bridge
module spbcr_io_decode (
  // Request address and window
  input  wire logic [31:0] io_addr,
  input  wire logic [31:0] io_base,
  input  wire logic [31:0] io_limit,
  // Bridge control
  input  wire logic        isa_en,
  input  wire logic        vga_en,
  input  wire logic        vga_wide,
  // Decision
  output logic             go_down,
  output logic             go_up
);

  logic in_win;
  logic isa_hit;
  logic vga_low;
  logic vga_hit;

  always_comb begin
    in_win  = (io_addr >= io_base) && (io_addr <= io_limit);
    // Top 768 bytes of each 1 KB block inside the first 64 KB
    isa_hit = isa_en && (io_addr < spbcr_pkg::ISA_SPAN) && (io_addr[9:8] != 2'h0);
    vga_low = ((io_addr[9:0] >= spbcr_pkg::VGA_A_LO) && (io_addr[9:0] <= spbcr_pkg::VGA_A_HI))
           || ((io_addr[9:0] >= spbcr_pkg::VGA_B_LO) && (io_addr[9:0] <= spbcr_pkg::VGA_B_HI));
    // Narrow decode aliases every 1 KB; wide decode needs the upper bits zero
    vga_hit = vga_en && vga_low && (!vga_wide || (io_addr[31:10] == 22'h0));
    // VGA claim beats ISA upstream routing, as legacy graphics must reach the card
    go_down = vga_hit || (in_win && !isa_hit);
    go_up   = !vga_hit && in_win && isa_hit;
  end

endmodule : spbcr_io_decode

// file: hw/spbcr_pkg.sv
// Constants for the switch port bridge configuration register bank
package spbcr_pkg;

  // ********************************************************************
  // Register indices (word index; byte address is four times the index)
  // ********************************************************************
  localparam logic [9:0] PIN_IDX    = 10'h03D;
  localparam logic [9:0] BRCTL_IDX  = 10'h03E;
  localparam logic [9:0] CAP_IDX    = 10'h040;
  localparam logic [9:0] LOCK_IDX   = 10'h03F;

  // ********************************************************************
  // Reset values and write masks
  // ********************************************************************
  localparam logic [7:0]  PIN_RST    = 8'h00;
  localparam logic [7:0]  PIN_MAX    = 8'h04;
  localparam logic [15:0] BRCTL_RST   = 16'h0000;
  localparam logic [15:0] BRCTL_WMASK = 16'h005F;
  localparam logic [7:0]  CAP_ID      = 8'h10;
  localparam logic [7:0]  NEXT_RST    = 8'hC0;
  localparam logic [3:0]  VSN_RST     = 4'h1;
  localparam logic [3:0]  TYPE_UP     = 4'h5;
  localparam logic [3:0]  TYPE_DOWN   = 4'h6;
  localparam logic        SLOT_RST    = 1'b0;
  localparam logic        TCR_RST     = 1'b1;

  // ********************************************************************
  // Bridge control field positions
  // ********************************************************************
  localparam int POISON_BIT = 0;
  localparam int ERRFWD_BIT = 1;
  localparam int ISA_BIT    = 2;
  localparam int VGA_BIT    = 3;
  localparam int VGA16_BIT  = 4;
  localparam int SECONDARY_BUS_RESET_BIT = 6;

  // ********************************************************************
  // Capability header field positions
  // ********************************************************************
  localparam int NEXT_LSB = 8;
  localparam int VSN_LSB  = 16;
  localparam int TYPE_LSB = 20;
  localparam int SLOT_BIT = 24;
  localparam int TCR_BIT  = 30;

  // ********************************************************************
  // I/O decode constants
  // ********************************************************************
  localparam logic [31:0] ISA_SPAN   = 32'h0001_0000;
  localparam logic [9:0]  VGA_A_LO   = 10'h3B0;
  localparam logic [9:0]  VGA_A_HI   = 10'h3BB;
  localparam logic [9:0]  VGA_B_LO   = 10'h3C0;
  localparam logic [9:0]  VGA_B_HI   = 10'h3DF;

  // ********************************************************************
  // Bus answer states
  // ********************************************************************
  typedef enum logic [1:0] {
    SPBCR_IDLE = 2'b01,
    SPBCR_ANS  = 2'b10
  } spbcr_bus_t;

endpackage : spbcr_pkg

// file: hw/spbcr_regs.sv
// Switch port bridge control and express capability header registers
//
// Function
// - Interrupt pin resets to zero; codes one to four pick lines A to D.
// - Poison response bit clear ignores secondary poisoned packets; set reports them.
// - Bit 1 gates forwarding of nonfatal and fatal errors to primary.
// - Forwarded errors also need command or device control reporting enabled.
// - ISA bit clear sends every in-window I/O address downstream.
// - ISA bit set sends ISA-range in-window addresses upstream instead, unless a VGA decode claims them.
// - Bit 3 blocks or forwards VGA-compatible addresses downstream.
// - Bit 4 picks 10-bit aliased or 16-bit unaliased VGA decode.
// - VGA decode width matters only while VGA forwarding is enabled.
// - Bit 6 drives secondary bus reset, upstream or downstream by port.
// - Capability bits 7:0 are read-only and return 0x10.
// - Next pointer resets to 0xC0, writable only while unlocked.
// - Version field resets to 0x1 and is lockable-writable.
// - Port type reads 0x5 upstream, 0x6 downstream.
// - Slot bit resets to zero and is lockable-writable.
// - Interrupt message number always reads zero.
// - Traffic class routing bit resets to one, lockable-writable.
module spbcr_regs #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Port strap
  input  wire logic              port_is_upstream,
  // Error and poison events from the secondary side, and the reporting enables
  input  wire logic              sec_poison_seen,
  input  wire logic              sec_err_nonfatal,
  input  wire logic              sec_err_fatal,
  input  wire logic              cmd_serr_enable,
  input  wire logic              dev_ctl_report_enable,
  // I/O routing request
  input  wire logic              io_req,
  input  wire logic [31:0]       io_addr,
  input  wire logic [31:0]       io_base,
  input  wire logic [31:0]       io_limit,
  // Registered results
  output logic                   poison_report,
  output logic                   err_forward,
  output logic                   io_fwd_down,
  output logic                   io_fwd_up,
  output logic                   sec_reset_up,
  output logic                   sec_reset_down,
  output logic [7:0]             legacy_int_pin
);

  if (ADDR_W < 10 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must lie between 10 and 32");
  end

  // ********************************************************************
  // Address decode
  // ********************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : hit

  // ********************************************************************
  // State
  // ********************************************************************
  spbcr_pkg::spbcr_bus_t bus_reg,     bus_next;
  logic [31:0]           rdata_reg,   rdata_next;
  logic                  err_reg,     err_next;
  logic [7:0]            pin_reg,     pin_next;
  logic [15:0]           brctl_reg,   brctl_next;
  logic [7:0]            nxt_reg,     nxt_next;
  logic [3:0]            vsn_reg,     vsn_next;
  logic                  slot_reg,    slot_next;
  logic                  tcr_reg,     tcr_next;
  logic                  lock_reg,    lock_next;
  logic                  up_reg,      up_next;
  logic                  strap_reg,   strap_next;
  logic                  poison_reg,  poison_next;
  logic                  errfwd_reg,  errfwd_next;
  logic                  down_reg,    down_next;
  logic                  upfwd_reg,   upfwd_next;
  logic                  sru_reg,     sru_next;
  logic                  srd_reg,     srd_next;
  logic [31:0]           cap_word;
  logic                  wr_take;
  logic                  dec_down;
  logic                  dec_up;

  // ********************************************************************
  // Routing decode
  // ********************************************************************
  spbcr_io_decode u_dec (
    .io_addr  (io_addr),
    .io_base  (io_base),
    .io_limit (io_limit),
    .isa_en   (brctl_reg[spbcr_pkg::ISA_BIT]),
    .vga_en   (brctl_reg[spbcr_pkg::VGA_BIT]),
    .vga_wide (brctl_reg[spbcr_pkg::VGA16_BIT]),
    .go_down  (dec_down),
    .go_up    (dec_up)
  );

  // ********************************************************************
  // Bus and register next values
  // ********************************************************************
  always_comb begin
    cap_word = 32'h0;
    cap_word[7:0] = spbcr_pkg::CAP_ID;
    cap_word[spbcr_pkg::NEXT_LSB +: 8] = nxt_reg;
    cap_word[spbcr_pkg::VSN_LSB +: 4] = vsn_reg;
    cap_word[spbcr_pkg::TYPE_LSB +: 4] = up_reg ? spbcr_pkg::TYPE_UP
                                                : spbcr_pkg::TYPE_DOWN;
    cap_word[spbcr_pkg::SLOT_BIT] = slot_reg;
    cap_word[spbcr_pkg::TCR_BIT] = tcr_reg;
    bus_next   = bus_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    pin_next   = pin_reg;
    brctl_next = brctl_reg;
    nxt_next   = nxt_reg;
    vsn_next   = vsn_reg;
    slot_next  = slot_reg;
    tcr_next   = tcr_reg;
    lock_next  = lock_reg;
    wr_take    = 1'b0;
    case (bus_reg)
      spbcr_pkg::SPBCR_IDLE: begin
        // One wait state lets read data and error come from flip-flops
        if (psel && penable) begin
          bus_next   = spbcr_pkg::SPBCR_ANS;
          err_next   = 1'b0;
          rdata_next = 32'h0;
          if (hit(paddr, spbcr_pkg::PIN_IDX)) begin
            rdata_next = {24'h0, pin_reg};
          end else if (hit(paddr, spbcr_pkg::BRCTL_IDX)) begin
            rdata_next = {16'h0, brctl_reg};
          end else if (hit(paddr, spbcr_pkg::LOCK_IDX)) begin
            rdata_next = {31'h0, lock_reg};
          end else if (hit(paddr, spbcr_pkg::CAP_IDX)) begin
            rdata_next = cap_word;
          end else begin
            err_next = 1'b1;
          end
          if (pwrite) begin
            rdata_next = 32'h0;
          end
        end
      end
      spbcr_pkg::SPBCR_ANS: begin
        bus_next = spbcr_pkg::SPBCR_IDLE;
        wr_take  = pwrite && !err_reg;
        err_next = 1'b0;
      end
      default: begin
        bus_next = spbcr_pkg::SPBCR_IDLE;
      end
    endcase
    if (wr_take) begin
      if (hit(paddr, spbcr_pkg::PIN_IDX)) begin
        if (pstrb[0]) begin
          pin_next = pwdata[7:0];
        end
      end else if (hit(paddr, spbcr_pkg::BRCTL_IDX)) begin
        if (pstrb[0]) begin
          brctl_next[7:0] = pwdata[7:0] & spbcr_pkg::BRCTL_WMASK[7:0];
        end
        if (pstrb[1]) begin
          brctl_next[15:8] = pwdata[15:8] & spbcr_pkg::BRCTL_WMASK[15:8];
        end
      end else if (hit(paddr, spbcr_pkg::LOCK_IDX)) begin
        if (pstrb[0]) begin
          lock_next = pwdata[0];
        end
      end else if (hit(paddr, spbcr_pkg::CAP_IDX)) begin
        // Locked fields keep firmware-set values against stray writes
        if (!lock_reg && pstrb[1]) begin
          nxt_next = pwdata[spbcr_pkg::NEXT_LSB +: 8];
        end
        if (!lock_reg && pstrb[2]) begin
          vsn_next = pwdata[spbcr_pkg::VSN_LSB +: 4];
        end
        if (!lock_reg && pstrb[3]) begin
          slot_next = pwdata[spbcr_pkg::SLOT_BIT];
          tcr_next  = pwdata[spbcr_pkg::TCR_BIT];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_reg   <= spbcr_pkg::SPBCR_IDLE;
      rdata_reg <= 32'h0;
      err_reg   <= 1'b0;
      pin_reg   <= spbcr_pkg::PIN_RST;
      brctl_reg <= spbcr_pkg::BRCTL_RST;
      nxt_reg   <= spbcr_pkg::NEXT_RST;
      vsn_reg   <= spbcr_pkg::VSN_RST;
      slot_reg  <= spbcr_pkg::SLOT_RST;
      tcr_reg   <= spbcr_pkg::TCR_RST;
      lock_reg  <= 1'b0;
    end else begin
      bus_reg   <= bus_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
      pin_reg   <= pin_next;
      brctl_reg <= brctl_next;
      nxt_reg   <= nxt_next;
      vsn_reg   <= vsn_next;
      slot_reg  <= slot_next;
      tcr_reg   <= tcr_next;
      lock_reg  <= lock_next;
    end
  end

  // ********************************************************************
  // Strap capture and event outputs
  // ********************************************************************
  always_comb begin
    strap_next  = 1'b1;
    up_next     = strap_reg ? up_reg : port_is_upstream;
    poison_next = sec_poison_seen && brctl_reg[spbcr_pkg::POISON_BIT];
    errfwd_next = (sec_err_nonfatal || sec_err_fatal)
               && brctl_reg[spbcr_pkg::ERRFWD_BIT]
               && (cmd_serr_enable || dev_ctl_report_enable);
    down_next   = io_req && dec_down;
    upfwd_next  = io_req && dec_up;
    sru_next    = brctl_reg[spbcr_pkg::SECONDARY_BUS_RESET_BIT] && up_reg;
    srd_next    = brctl_reg[spbcr_pkg::SECONDARY_BUS_RESET_BIT] && !up_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_reg  <= 1'b0;
      up_reg     <= 1'b0;
      poison_reg <= 1'b0;
      errfwd_reg <= 1'b0;
      down_reg   <= 1'b0;
      upfwd_reg  <= 1'b0;
      sru_reg    <= 1'b0;
      srd_reg    <= 1'b0;
    end else begin
      strap_reg  <= strap_next;
      up_reg     <= up_next;
      poison_reg <= poison_next;
      errfwd_reg <= errfwd_next;
      down_reg   <= down_next;
      upfwd_reg  <= upfwd_next;
      sru_reg    <= sru_next;
      srd_reg    <= srd_next;
    end
  end

  always_comb begin
    prdata         = rdata_reg;
    pready         = (bus_reg == spbcr_pkg::SPBCR_ANS);
    pslverr        = err_reg;
    poison_report  = poison_reg;
    err_forward    = errfwd_reg;
    io_fwd_down    = down_reg;
    io_fwd_up      = upfwd_reg;
    sec_reset_up   = sru_reg;
    sec_reset_down = srd_reg;
    legacy_int_pin = pin_reg;
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc_end;
  assign acc_end = psel && penable && pready;

  pin_write_a: assert property (
    acc_end && pwrite && !pslverr && hit(paddr, spbcr_pkg::PIN_IDX) && pstrb[0]
    |=> legacy_int_pin == $past(pwdata[7:0]))
    else $error("interrupt pin write lost");

  poison_gate_a: assert property (
    poison_report |-> $past(sec_poison_seen) && $past(brctl_reg[spbcr_pkg::POISON_BIT]))
    else $error("poison reported while disabled");

  err_fwd_a: assert property (
    sec_err_fatal && !cmd_serr_enable && !dev_ctl_report_enable |=> !err_forward)
    else $error("error forwarded without reporting enable");

  err_on_a: assert property (
    sec_err_nonfatal && brctl_reg[spbcr_pkg::ERRFWD_BIT] && cmd_serr_enable |=> err_forward)
    else $error("enabled error not forwarded");

  down_route_a: assert property (
    io_req && !brctl_reg[spbcr_pkg::ISA_BIT] && io_addr >= io_base && io_addr <= io_limit
    |=> io_fwd_down && !io_fwd_up)
    else $error("in-window address not sent downstream");

  vga_block_a: assert property (
    io_req && !brctl_reg[spbcr_pkg::VGA_BIT] && !(io_addr >= io_base && io_addr <= io_limit)
    |=> !io_fwd_down)
    else $error("VGA address forwarded while blocked");

  secondary_bus_reset_a: assert property (
    brctl_reg[spbcr_pkg::SECONDARY_BUS_RESET_BIT] && !up_reg |=> sec_reset_down)
    else $error("downstream secondary reset missing");

  cap_read_a: assert property (
    acc_end && !pwrite && hit(paddr, spbcr_pkg::CAP_IDX)
    |-> prdata[7:0] == spbcr_pkg::CAP_ID && prdata[31] == 1'b0 && prdata[29:25] == 5'h00)
    else $error("capability header read wrong");

  lock_hold_a: assert property (
    lock_reg && acc_end && pwrite && hit(paddr, spbcr_pkg::CAP_IDX) |=> $stable(nxt_reg))
    else $error("next pointer changed while locked");

  ctl_rsv_a: assert property (
    (brctl_reg & ~spbcr_pkg::BRCTL_WMASK) == 16'h0000)
    else $error("reserved control bit set");

  answer_a: assert property (
    psel && penable && !pready |=> pready)
    else $error("bus answer late");

  up_isa_c:  cover property (io_req ##1 io_fwd_up);
  secondary_bus_reset_c:  cover property (sec_reset_up or sec_reset_down);
  unmap_c:   cover property (pslverr);
  locked_c:  cover property (lock_reg && acc_end && pwrite);

endmodule : spbcr_regs
